// ==== dphu_top.sv ====
// data prefetch hint unit: executes both prefetch forms against translation and data cache
`timescale 1ns/1ns
`default_nettype none
`include "dphu_consts.svh"
module dphu_top
	import dphu_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  reset_in,
	// issue from the pipeline
	input  wire logic                  issue_valid_in,
	input  wire logic [`DPHU_XLEN-1:0] instr_in,
	input  wire logic [`DPHU_XLEN-1:0] base_val_in,
	output logic                       issue_ready_out,
	// mode
	input  wire logic                  cp0_enabled_in,
	input  wire logic                  enhanced_vaddr_present_flag_in,
	// address translation
	output logic                       xlate_req_out,
	output logic [`DPHU_XLEN-1:0]      xlate_vaddr_out,
	output logic                       xlate_user_map_out,
	input  wire logic                  xlate_done_in,
	input  wire dphu_xlate_rsp_s       xlate_rsp_in,
	// data cache
	output logic                       cache_req_valid_out,
	output dphu_cache_req_s            cache_req_out,
	input  wire logic                  cache_done_in,
	input  wire dphu_cache_rsp_s       cache_rsp_in,
	// retirement
	output logic                       retire_out,
	output dphu_exc_e                  exc_code_out,
	output logic                       general_reg_we_out
);
	typedef enum logic [2:0] {S_IDLE, S_XLATE, S_PROBE, S_CMD, S_RETIRE} dphu_state_e;

	dphu_state_e                state;
	dphu_state_e                next_state;
	dphu_exc_e                  next_exc;
	dphu_hint_s                 hint_q;
	dphu_hint_s                 dec_hint;
	dphu_xlate_rsp_s            xl_q;
	logic                       user_q;
	logic                       probe_hit_q;
	logic                       dec_ord;
	logic                       dec_user;
	logic [`DPHU_HINT_W-1:0]    dec_hint_raw;
	logic [`DPHU_XLEN-1:0]      dec_ea;
	logic                       accept;
	logic                       xl_done;
	logic                       pr_done;
	logic                       pr_skip;
	logic                       err_seen;
	dphu_exc_e                  err_exc;
	dphu_ckind_e                cmd_kind;

	dphu_decode u_decode (
		.instr_in     (instr_in),
		.base_val_in  (base_val_in),
		.is_ord_out   (dec_ord),
		.is_user_out  (dec_user),
		.hint_out     (dec_hint_raw),
		.eff_addr_out (dec_ea)
	);

	dphu_hint_map u_hint_map (
		.hint_in    (dec_hint_raw),
		.action_out (dec_hint)
	);

	assign accept  = issue_valid_in && issue_ready_out && (state == S_IDLE);
	assign xl_done = (state == S_XLATE) && xlate_done_in;
	assign pr_done = (state == S_PROBE) && cache_done_in;

	// probe outcome that ends the instruction without touching the line
	always_comb
	begin
		pr_skip = 1'b1;
		if (cache_rsp_in.locked)
			pr_skip = 1'b1;
		else
			unique case (hint_q.act)
				DPHU_ACT_FETCH: pr_skip = cache_rsp_in.hit;
				DPHU_ACT_ZERO:  pr_skip = cache_rsp_in.hit;
				// clean lines are left valid: invalidating them buys nothing
				DPHU_ACT_WBINV: pr_skip = !(cache_rsp_in.hit && cache_rsp_in.dirty);
				DPHU_ACT_NONE:  pr_skip = 1'b1;
			endcase
	end

	// only bus and cache errors escape, and only when reporting is on
	always_comb
	begin
		err_seen = `DPHU_REPORT_ERR && (cache_rsp_in.bus_err || cache_rsp_in.cache_err);
		err_exc  = cache_rsp_in.bus_err ? DPHU_EXC_BUS : DPHU_EXC_CACHE;
	end

	always_comb
	begin
		unique case (hint_q.act)
			DPHU_ACT_WBINV: cmd_kind = DPHU_CK_WBINV;
			DPHU_ACT_ZERO:  cmd_kind = DPHU_CK_ZERO;
			default:        cmd_kind = DPHU_CK_FETCH;
		endcase
	end

	always_comb
	begin
		next_state = state;
		next_exc   = DPHU_EXC_NONE;
		unique case (state)
			S_IDLE:
			begin
				if (accept)
				begin
					if (!dec_ord && !dec_user)
					begin
						next_state = S_RETIRE;
						next_exc   = DPHU_EXC_RESV;
					end
					else if (dec_user && !enhanced_vaddr_present_flag_in)
					begin
						next_state = S_RETIRE;
						next_exc   = DPHU_EXC_RESV;
					end
					else if (dec_user && !cp0_enabled_in)
					begin
						next_state = S_RETIRE;
						next_exc   = DPHU_EXC_COPU;
					end
					else
						next_state = S_XLATE;
				end
			end
			S_XLATE:
			begin
				if (xlate_done_in)
				begin
					if (user_q && !xlate_rsp_in.seg_user_ok)
					begin
						next_state = S_RETIRE;
						next_exc   = DPHU_EXC_RESV;
					end
					// faults vanish, uncached targets and idle hints touch nothing
					else if (xlate_rsp_in.fault || xlate_rsp_in.uncached
						|| (hint_q.act == DPHU_ACT_NONE))
						next_state = S_RETIRE;
					else
						next_state = S_PROBE;
				end
			end
			S_PROBE:
			begin
				if (cache_done_in)
				begin
					if (err_seen)
					begin
						next_state = S_RETIRE;
						next_exc   = err_exc;
					end
					else if (pr_skip)
						next_state = S_RETIRE;
					else
						next_state = S_CMD;
				end
			end
			S_CMD:
			begin
				// retirement waits for the fill or writeback to complete
				if (cache_done_in)
				begin
					next_state = S_RETIRE;
					if (err_seen)
						next_exc = err_exc;
				end
			end
			S_RETIRE:
				next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
			issue_ready_out <= 1'b0;
		else
			issue_ready_out <= (next_state == S_IDLE);
	end

	// instruction context held for the whole sequence
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			hint_q <= '{DPHU_ACT_NONE, 1'b0, DPHU_PLACE_NORMAL};
			user_q <= 1'b0;
		end
		else if (accept)
		begin
			hint_q <= dec_hint;
			user_q <= dec_user;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			xlate_req_out      <= 1'b0;
			xlate_vaddr_out    <= '0;
			xlate_user_map_out <= 1'b0;
		end
		else
		begin
			xlate_req_out <= (next_state == S_XLATE) && !xl_done;
			if (accept)
			begin
				xlate_vaddr_out    <= dec_ea;
				xlate_user_map_out <= dec_user;
			end
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
			xl_q <= '0;
		else if (xl_done)
			xl_q <= xlate_rsp_in;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
			probe_hit_q <= 1'b0;
		else if (pr_done)
			probe_hit_q <= cache_rsp_in.hit;
	end

	// one request outstanding; valid drops for a cycle between probe and command
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			cache_req_valid_out <= 1'b0;
			cache_req_out       <= '0;
		end
		else
		begin
			cache_req_valid_out <= ((next_state == S_PROBE) || (next_state == S_CMD))
				&& !cache_done_in;
			if (xl_done)
			begin
				cache_req_out.kind                 <= DPHU_CK_PROBE;
				cache_req_out.paddr                <= xlate_rsp_in.paddr;
				cache_req_out.cache_coherency_attr <= xlate_rsp_in.cache_coherency_attr;
				cache_req_out.coherent             <= xlate_rsp_in.coherent;
				cache_req_out.for_store            <= hint_q.for_store;
				cache_req_out.place                <= hint_q.place;
			end
			else if (pr_done)
				cache_req_out.kind <= cmd_kind;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			retire_out   <= 1'b0;
			exc_code_out <= DPHU_EXC_NONE;
		end
		else
		begin
			retire_out   <= (next_state == S_RETIRE);
			exc_code_out <= (next_state == S_RETIRE) ? next_exc : DPHU_EXC_NONE;
		end
	end

	// the unit has no result path; the strobe exists so the pipeline sees it held low
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
			general_reg_we_out <= 1'b0;
		else
			general_reg_we_out <= 1'b0;
	end

	default clocking dphu_cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	chk_no_reg_write: assert property (accept |-> ##[1:3] !general_reg_we_out)
		else $error("prefetch drove the general register write strobe");
	chk_fault_silent: assert property (xl_done && xlate_rsp_in.fault && !user_q
		|=> retire_out && (exc_code_out == DPHU_EXC_NONE) && !cache_req_valid_out)
		else $error("translation fault escaped or moved data");
	chk_uncached_idle: assert property (xl_done && xlate_rsp_in.uncached
		|=> (!cache_req_valid_out) [*2])
		else $error("uncached target reached the cache");
	chk_locked_kept: assert property (pr_done && cache_rsp_in.locked
		|=> retire_out && !cache_req_valid_out)
		else $error("locked line was acted upon");
	chk_attr_follows: assert property (cache_req_valid_out
		|-> (cache_req_out.cache_coherency_attr == xl_q.cache_coherency_attr)
		&& (cache_req_out.coherent == xl_q.coherent))
		else $error("cache request attribute differs from translation");
	chk_flag_gates_user: assert property (accept && dec_user && !enhanced_vaddr_present_flag_in
		|=> retire_out && (exc_code_out == DPHU_EXC_RESV))
		else $error("kernel form ran without the enhanced addressing flag");
	chk_cp0_gates_user: assert property (accept && dec_user && enhanced_vaddr_present_flag_in
		&& !cp0_enabled_in |=> exc_code_out == DPHU_EXC_COPU)
		else $error("kernel form ran without coprocessor access");
	chk_single_outstand: assert property (cache_req_valid_out && cache_done_in
		|=> !cache_req_valid_out)
		else $error("cache request stayed up after completion");
	chk_zero_on_miss: assert property ($rose(cache_req_valid_out)
		&& (cache_req_out.kind == DPHU_CK_ZERO) |-> !probe_hit_q && (state == S_CMD))
		else $error("zero fill issued on a hit");
	chk_hint_noop: assert property (xl_done && (hint_q.act == DPHU_ACT_NONE)
		|=> retire_out && !cache_req_valid_out)
		else $error("reserved hint reached the cache");
	chk_user_mapping: assert property (xlate_req_out |-> xlate_user_map_out == user_q)
		else $error("translation mapping does not match instruction form");

	cov_zero_fill: cover property ($rose(cache_req_valid_out) && cache_req_out.kind == DPHU_CK_ZERO);
	cov_wb_inv: cover property ($rose(cache_req_valid_out) && cache_req_out.kind == DPHU_CK_WBINV);
	cov_retained: cover property ($rose(cache_req_valid_out) && cache_req_out.kind == DPHU_CK_FETCH
		&& cache_req_out.place == DPHU_PLACE_RETAIN);
	cov_fault_drop: cover property (xl_done && xlate_rsp_in.fault ##1 retire_out);
endmodule : dphu_top
`default_nettype wire

// ==== dphu_consts.svh ====
// constants for the data prefetch hint unit
`ifndef DPHU_CONSTS_SVH
`define DPHU_CONSTS_SVH

`define DPHU_XLEN        32
`define DPHU_CCA_W       3
`define DPHU_HINT_W      5
`define DPHU_OPC_W       6
`define DPHU_OPC_MSB     31
`define DPHU_OPC_LSB     26
`define DPHU_HINT_MSB    20
`define DPHU_HINT_LSB    16
`define DPHU_FN_MSB      5
`define DPHU_FN_LSB      0
`define DPHU_OFF16_MSB   15
`define DPHU_OFF16_LSB   0
`define DPHU_OFF16_W     16
`define DPHU_OFF9_MSB    15
`define DPHU_OFF9_LSB    7
`define DPHU_OFF9_W      9
`define DPHU_ZBIT_POS    6

`define DPHU_OP_ORD      6'h33
`define DPHU_OP_SPEC3    6'h1F
`define DPHU_FN_USER     6'h23

`define DPHU_HINT_LOAD   5'h00
`define DPHU_HINT_STORE  5'h01
`define DPHU_HINT_LD_STR 5'h04
`define DPHU_HINT_ST_STR 5'h05
`define DPHU_HINT_LD_RET 5'h06
`define DPHU_HINT_ST_RET 5'h07
`define DPHU_HINT_WBINV  5'h19
`define DPHU_HINT_ZERO   5'h1E

`define DPHU_REPORT_ERR  1'b1

`endif

// ==== dphu_pkg.sv ====
// types shared by the data prefetch hint unit
`default_nettype none
`include "dphu_consts.svh"
package dphu_pkg;
	typedef enum logic [1:0] {DPHU_ACT_NONE, DPHU_ACT_FETCH, DPHU_ACT_WBINV, DPHU_ACT_ZERO} dphu_act_e;
	typedef enum logic [1:0] {DPHU_PLACE_NORMAL, DPHU_PLACE_STREAM, DPHU_PLACE_RETAIN} dphu_place_e;
	typedef enum logic [1:0] {DPHU_CK_PROBE, DPHU_CK_FETCH, DPHU_CK_WBINV, DPHU_CK_ZERO} dphu_ckind_e;
	typedef enum logic [2:0] {DPHU_EXC_NONE, DPHU_EXC_RESV, DPHU_EXC_COPU, DPHU_EXC_BUS,
		DPHU_EXC_CACHE} dphu_exc_e;
	typedef struct packed {
		dphu_act_e   act;
		logic        for_store;
		dphu_place_e place;
	} dphu_hint_s;
	typedef struct packed {
		logic [`DPHU_XLEN-1:0]  paddr;
		logic [`DPHU_CCA_W-1:0] cache_coherency_attr;
		logic                   coherent;
		logic                   uncached;
		logic                   fault;
		logic                   seg_user_ok;
	} dphu_xlate_rsp_s;
	typedef struct packed {
		dphu_ckind_e            kind;
		logic [`DPHU_XLEN-1:0]  paddr;
		logic [`DPHU_CCA_W-1:0] cache_coherency_attr;
		logic                   coherent;
		logic                   for_store;
		dphu_place_e            place;
	} dphu_cache_req_s;
	typedef struct packed {
		logic hit;
		logic locked;
		logic dirty;
		logic bus_err;
		logic cache_err;
	} dphu_cache_rsp_s;
endpackage : dphu_pkg
`default_nettype wire

// ==== dphu_decode.sv ====
// instruction decode and effective address for both prefetch forms
`timescale 1ns/1ns
`default_nettype none
`include "dphu_consts.svh"
module dphu_decode
	import dphu_pkg::*;
(
	// instruction and base operand
	input  wire logic [`DPHU_XLEN-1:0]   instr_in,
	input  wire logic [`DPHU_XLEN-1:0]   base_val_in,
	// decoded fields
	output logic                         is_ord_out,
	output logic                         is_user_out,
	output logic [`DPHU_HINT_W-1:0]      hint_out,
	output logic [`DPHU_XLEN-1:0]        eff_addr_out
);
	logic [`DPHU_OPC_W-1:0]  opc;
	logic [`DPHU_OPC_W-1:0]  fn;
	logic [`DPHU_OFF16_W-1:0] off16;
	logic [`DPHU_OFF9_W-1:0]  off9;

	assign opc     = instr_in[`DPHU_OPC_MSB:`DPHU_OPC_LSB];
	assign fn      = instr_in[`DPHU_FN_MSB:`DPHU_FN_LSB];
	assign off16   = instr_in[`DPHU_OFF16_MSB:`DPHU_OFF16_LSB];
	assign off9    = instr_in[`DPHU_OFF9_MSB:`DPHU_OFF9_LSB];
	assign hint_out = instr_in[`DPHU_HINT_MSB:`DPHU_HINT_LSB];
	assign is_ord_out = (opc == `DPHU_OP_ORD);
	// a set zero bit means some other third-group instruction, not ours
	assign is_user_out = (opc == `DPHU_OP_SPEC3) && (fn == `DPHU_FN_USER)
		&& !instr_in[`DPHU_ZBIT_POS];

	always_comb
	begin
		if (is_user_out)
			eff_addr_out = base_val_in
				+ {{(`DPHU_XLEN-`DPHU_OFF9_W){off9[`DPHU_OFF9_W-1]}}, off9};
		else
			eff_addr_out = base_val_in
				+ {{(`DPHU_XLEN-`DPHU_OFF16_W){off16[`DPHU_OFF16_W-1]}}, off16};
	end
endmodule : dphu_decode
`default_nettype wire

// ==== dphu_hint_map.sv ====
// maps the 5-bit hint onto a cache action, direction and placement class
`timescale 1ns/1ns
`default_nettype none
`include "dphu_consts.svh"
module dphu_hint_map
	import dphu_pkg::*;
(
	// raw hint
	input  wire logic [`DPHU_HINT_W-1:0] hint_in,
	// action
	output dphu_hint_s                   action_out
);
	always_comb
	begin
		action_out = '{act: DPHU_ACT_NONE, for_store: 1'b0, place: DPHU_PLACE_NORMAL};
		unique case (hint_in)
			`DPHU_HINT_LOAD:   action_out.act = DPHU_ACT_FETCH;
			`DPHU_HINT_STORE:  action_out = '{DPHU_ACT_FETCH, 1'b1, DPHU_PLACE_NORMAL};
			`DPHU_HINT_LD_STR: action_out = '{DPHU_ACT_FETCH, 1'b0, DPHU_PLACE_STREAM};
			`DPHU_HINT_ST_STR: action_out = '{DPHU_ACT_FETCH, 1'b1, DPHU_PLACE_STREAM};
			`DPHU_HINT_LD_RET: action_out = '{DPHU_ACT_FETCH, 1'b0, DPHU_PLACE_RETAIN};
			`DPHU_HINT_ST_RET: action_out = '{DPHU_ACT_FETCH, 1'b1, DPHU_PLACE_RETAIN};
			`DPHU_HINT_WBINV:  action_out.act = DPHU_ACT_WBINV;
			`DPHU_HINT_ZERO:   action_out = '{DPHU_ACT_ZERO, 1'b1, DPHU_PLACE_NORMAL};
			// reserved and unassigned values retire with no action
			default:           action_out.act = DPHU_ACT_NONE;
		endcase
	end
endmodule : dphu_hint_map
`default_nettype wire

// ==== dphu_partner.sv ====
// far-side model: address translation and data cache responders with settable latency
`timescale 1ns/1ns
`default_nettype none
module dphu_partner
	import dphu_pkg::*;
(
	// clock and reset
	input  wire logic            clk_sys_in,
	input  wire logic            reset_in,
	// settings from the bench
	input  wire logic [3:0]      lat_in,
	input  wire dphu_xlate_rsp_s xlate_cfg_in,
	input  wire dphu_cache_rsp_s probe_cfg_in,
	input  wire dphu_cache_rsp_s cmd_cfg_in,
	// translation side
	input  wire logic            xlate_req_in,
	output logic                 xlate_done_out,
	output dphu_xlate_rsp_s      xlate_rsp_out,
	// cache side
	input  wire logic            cache_req_valid_in,
	input  wire dphu_cache_req_s cache_req_in,
	output logic                 cache_done_out,
	output dphu_cache_rsp_s      cache_rsp_out
);
	logic [3:0]      x_wait;
	logic [3:0]      c_wait;
	dphu_cache_rsp_s c_sel;

	// the done guard stops a second answer while the request is still dropping
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in || !xlate_req_in || xlate_done_out)
		begin
			x_wait         <= 4'h0;
			xlate_done_out <= 1'b0;
		end
		else if (x_wait == lat_in)
			xlate_done_out <= 1'b1;
		else
			x_wait <= x_wait + 4'h1;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in || !cache_req_valid_in || cache_done_out)
		begin
			c_wait         <= 4'h0;
			cache_done_out <= 1'b0;
		end
		else if (c_wait == lat_in)
			cache_done_out <= 1'b1;
		else
			c_wait <= c_wait + 4'h1;
	end

	assign c_sel = (cache_req_in.kind == DPHU_CK_PROBE) ? probe_cfg_in : cmd_cfg_in;
	// outside the answer cycle the data is inverted so nothing stale looks valid
	assign xlate_rsp_out = xlate_done_out ? xlate_cfg_in : ~xlate_cfg_in;
	assign cache_rsp_out = cache_done_out ? c_sel : ~c_sel;
endmodule : dphu_partner
`default_nettype wire

// ==== tb_data_prefetch_hint_unit.sv ====
// self-checking bench for the data prefetch hint unit
`timescale 1ns/1ns
`default_nettype none
`include "dphu_consts.svh"
module tb_data_prefetch_hint_unit
	import dphu_pkg::*;
;
	logic            clk_sys_in, reset_in, issue_valid_in, issue_ready_out;
	logic            cp0_enabled_in, enhanced_vaddr_present_flag_in;
	logic [31:0]     instr_in, base_val_in, xlate_vaddr_out, xl_va;
	logic            xlate_req_out, xlate_user_map_out, xlate_done_in, xl_um;
	logic            cache_req_valid_out, cache_done_in, retire_out, general_reg_we_out;
	logic [3:0]      lat;
	dphu_xlate_rsp_s xlate_rsp_in, xlate_cfg;
	dphu_cache_rsp_s cache_rsp_in, probe_cfg, cmd_cfg;
	dphu_cache_req_s cache_req_out;
	dphu_cache_req_s cr_log [4];
	dphu_exc_e       exc_code_out, got_exc;
	int              error_cnt, n_compared, xl_cnt, cr_cnt;

	dphu_top dphu_top_inst (.clk_sys_in, .reset_in, .issue_valid_in, .instr_in, .base_val_in,
		.issue_ready_out, .cp0_enabled_in, .enhanced_vaddr_present_flag_in, .xlate_req_out,
		.xlate_vaddr_out, .xlate_user_map_out, .xlate_done_in, .xlate_rsp_in,
		.cache_req_valid_out, .cache_req_out, .cache_done_in, .cache_rsp_in, .retire_out,
		.exc_code_out, .general_reg_we_out);

	dphu_partner dphu_partner_inst (.clk_sys_in, .reset_in, .lat_in(lat),
		.xlate_cfg_in(xlate_cfg), .probe_cfg_in(probe_cfg), .cmd_cfg_in(cmd_cfg),
		.xlate_req_in(xlate_req_out), .xlate_done_out(xlate_done_in),
		.xlate_rsp_out(xlate_rsp_in), .cache_req_valid_in(cache_req_valid_out),
		.cache_req_in(cache_req_out), .cache_done_out(cache_done_in),
		.cache_rsp_out(cache_rsp_in));

	initial
	begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	task automatic give_up();
		error_cnt++;
		$display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
		complete_run();
	endtask : give_up

	// mid-cycle sampling keeps the log clear of edge races
	always @(negedge clk_sys_in)
	begin
		if (xlate_req_out === 1'b1 && xlate_done_in === 1'b1)
		begin
			xl_cnt++;
			xl_va = xlate_vaddr_out;
			xl_um = xlate_user_map_out;
		end
		if (cache_req_valid_out === 1'b1 && cache_done_in === 1'b1 && cr_cnt < 4)
		begin
			cr_log[cr_cnt] = cache_req_out;
			cr_cnt++;
		end
		if (reset_in === 1'b0)
			check(general_reg_we_out, 1'b0);
	end

	function automatic logic [31:0] ord(input logic [4:0] hint, input logic [15:0] off);
		return {`DPHU_OP_ORD, 5'h03, hint, off};
	endfunction : ord

	function automatic logic [31:0] usr(input logic [4:0] hint, input logic [8:0] off,
		input logic z);
		return {`DPHU_OP_SPEC3, 5'h03, hint, off, z, `DPHU_FN_USER};
	endfunction : usr

	task automatic run_op(input logic [31:0] instr, input logic [31:0] base, input logic cp0,
		input logic eva);
		int i;
		xl_cnt = 0;
		cr_cnt = 0;
		instr_in = instr;
		base_val_in = base;
		cp0_enabled_in = cp0;
		enhanced_vaddr_present_flag_in = eva;
		issue_valid_in = 1'b1;
		for (i = 0; i < 100 && issue_ready_out !== 1'b1; i++)
		begin
			@(posedge clk_sys_in);
			#2;
		end
		if (i == 100)
			give_up();
		@(posedge clk_sys_in);
		#2;
		issue_valid_in = 1'b0;
		for (i = 0; i < 300 && retire_out !== 1'b1; i++)
		begin
			@(posedge clk_sys_in);
			#2;
		end
		if (i == 300)
			give_up();
		got_exc = exc_code_out;
	endtask : run_op

	task automatic t_cache_table();
		logic [4:0]  hl [13] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h1E, 5'h00,
			5'h1E, 5'h19, 5'h19, 5'h19, 5'h01};
		logic [12:0] hit = 13'h0F80;
		logic [12:0] lck = 13'h1800;
		logic [12:0] drt = 13'h0A00;
		dphu_ckind_e ek;
		dphu_place_e ep;
		for (int i = 0; i < 13; i++)
		begin
			lat = 4'(i % 4);
			xlate_cfg = '{32'h0040_0A00 + 32'(i), 3'(i), i[0], 1'b0, 1'b0, 1'b1};
			probe_cfg = '{hit[i], lck[i], drt[i], 1'b0, 1'b0};
			cmd_cfg = '0;
			ek = lck[i] ? DPHU_CK_PROBE : (hl[i] == `DPHU_HINT_WBINV) ?
				((hit[i] && drt[i]) ? DPHU_CK_WBINV : DPHU_CK_PROBE) : hit[i] ? DPHU_CK_PROBE :
				(hl[i] == `DPHU_HINT_ZERO) ? DPHU_CK_ZERO : DPHU_CK_FETCH;
			ep = (hl[i][4:1] == 4'h2) ? DPHU_PLACE_STREAM :
				(hl[i][4:1] == 4'h3) ? DPHU_PLACE_RETAIN : DPHU_PLACE_NORMAL;
			run_op(ord(hl[i], 16'hFFF0), 32'h0000_1000, 1'b1, 1'b1);
			check(got_exc, DPHU_EXC_NONE);
			check(xl_va, 32'h0000_0FF0);
			check(xl_cnt, 1);
			check(xl_um, 1'b0);
			check(cr_cnt, (ek == DPHU_CK_PROBE) ? 1 : 2);
			check(cr_log[0].kind, DPHU_CK_PROBE);
			if (ek != DPHU_CK_PROBE)
			begin
				check(cr_log[1].kind, ek);
				check(cr_log[1].paddr, xlate_cfg.paddr);
				check({cr_log[1].cache_coherency_attr, cr_log[1].coherent},
					{xlate_cfg.cache_coherency_attr, xlate_cfg.coherent});
				if (ek != DPHU_CK_WBINV)
					check(cr_log[1].for_store, hl[i][0] || ek == DPHU_CK_ZERO);
				if (ek == DPHU_CK_FETCH)
					check(cr_log[1].place, ep);
			end
		end
	endtask : t_cache_table

	task automatic t_quiet_hints();
		xlate_cfg = '{32'h0000_8000, 3'h3, 1'b0, 1'b0, 1'b0, 1'b1};
		for (int h = 2; h < 32; h++)
			if (!(h inside {[4:7], 25, 30}))
			begin
				run_op(ord(5'(h), 16'h0004), 32'h0000_0100, 1'b1, 1'b1);
				check(got_exc, DPHU_EXC_NONE);
				check(cr_cnt, 0);
			end
	endtask : t_quiet_hints

	task automatic t_fault_uncached();
		for (int k = 0; k < 4; k++)
		begin
			xlate_cfg = '{32'h0000_2000, 3'h2, 1'b0, k[1], !k[1], 1'b1};
			run_op(ord(k[0] ? `DPHU_HINT_ZERO : `DPHU_HINT_WBINV, 16'h7FFF), 32'hFFFF_FFF0,
				1'b1, 1'b1);
			check(xl_va, 32'h0000_7FEF);
			check(got_exc, DPHU_EXC_NONE);
			check(cr_cnt, 0);
		end
	endtask : t_fault_uncached

	task automatic t_errors();
		dphu_exc_e ee [4] = '{DPHU_EXC_BUS, DPHU_EXC_CACHE, DPHU_EXC_BUS, DPHU_EXC_CACHE};
		xlate_cfg = '{32'h0000_3000, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1};
		for (int k = 0; k < 4; k++)
		begin
			probe_cfg = '{1'b0, 1'b0, 1'b0, k == 0 || k == 2, k == 1 || k == 2};
			cmd_cfg = '{1'b0, 1'b0, 1'b0, 1'b0, k == 3};
			run_op(ord(`DPHU_HINT_LOAD, 16'h0000), 32'h0000_3000, 1'b1, 1'b1);
			check(got_exc, ee[k]);
		end
	endtask : t_errors

	task automatic t_user_form();
		logic [31:0] iw [7] = '{usr(5'h00, 9'h1F8, 1'b0), usr(5'h00, 9'h1F8, 1'b0),
			usr(5'h00, 9'h1F8, 1'b0), usr(5'h00, 9'h1F8, 1'b0), usr(5'h00, 9'h1F8, 1'b1),
			32'h0000_0000, ord(5'h00, 16'hFFF8)};
		logic [6:0]  cp = 7'h3B;
		logic [6:0]  ev = 7'h3D;
		logic [6:0]  sok = 7'h77;
		dphu_exc_e   ee [7] = '{DPHU_EXC_NONE, DPHU_EXC_RESV, DPHU_EXC_COPU, DPHU_EXC_RESV,
			DPHU_EXC_RESV, DPHU_EXC_RESV, DPHU_EXC_NONE};
		probe_cfg = '0;
		cmd_cfg = '0;
		for (int k = 0; k < 7; k++)
		begin
			xlate_cfg = '{32'h0000_5000, 3'h3, 1'b0, 1'b0, 1'b0, sok[k]};
			run_op(iw[k], 32'h0000_2010, cp[k], ev[k]);
			check(got_exc, ee[k]);
			if (ee[k] == DPHU_EXC_NONE)
			begin
				check(xl_va, 32'h0000_2008);
				check(xl_um, k == 0);
				check(cr_cnt, 2);
			end
			else
				check(cr_cnt, 0);
		end
	endtask : t_user_form

	initial
	begin
		error_cnt = 0;
		n_compared = 0;
		xl_cnt = 0;
		cr_cnt = 0;
		reset_in = 1'b1;
		issue_valid_in = 1'b0;
		instr_in = '0;
		base_val_in = '0;
		cp0_enabled_in = 1'b0;
		enhanced_vaddr_present_flag_in = 1'b0;
		lat = 4'h0;
		xlate_cfg = '0;
		probe_cfg = '0;
		cmd_cfg = '0;
		repeat (12) @(posedge clk_sys_in);
		#2;
		reset_in = 1'b0;
		t_cache_table();
		t_quiet_hints();
		t_fault_uncached();
		t_errors();
		t_user_form();
		complete_run();
	end
endmodule : tb_data_prefetch_hint_unit
`default_nettype wire
